//--- hw/sercmd_decode.sv
// Module: pure command-byte decoder per the 16x16 command map
`timescale 1ns/1ps
module sercmd_decode
  import sercmd_pkg::*;
(
  input wire logic [7:0] cmd_i,
  output sercmd_pkg::sercmd_kind_t kind_o
);
  import sercmd_pkg::*;

  // ----------------------------------------
  // Map lookup
  // ----------------------------------------
  // Rows with bank operands accept low nibbles 0..7; rows 4 and D also accept 8 (all banks)
  always_comb
  begin
    kind_o = K_RESERVED; // Unlisted codes are reserved
    unique case (cmd_i[7:4])
      4'h0:
      begin
        if (cmd_i == CMD_READ_ONCE) kind_o = K_READ_ONCE;
        else if (cmd_i == CMD_READ_CONT) kind_o = K_READ_CONT;
        else if (cmd_i == CMD_STOP_CONT) kind_o = K_STOP_CONT;
      end
      ROW_REG_READ: kind_o = K_REG_READ;   // All 16 nibbles
      ROW_REG_WRITE: kind_o = K_REG_WRITE; // All 16 nibbles
      ROW_RAM_READ: if (!cmd_i[3]) kind_o = K_RAM_READ;
      ROW_RAM_WRITE: if (!cmd_i[3]) kind_o = K_RAM_WRITE;
      ROW_COPY_RAM: if (!cmd_i[3]) kind_o = K_COPY_RAM;
      ROW_COPY_REG:
        if (!cmd_i[3] || cmd_i[3:0] == ALL_BANKS_NIBBLE) kind_o = K_COPY_REG;
      ROW_SUM_MASKED:
      begin
        if (!cmd_i[3] || cmd_i[3:0] == ALL_BANKS_NIBBLE) kind_o = K_SUM_MASKED;
        else if (cmd_i == CMD_SUM_REGS) kind_o = K_SUM_REGS;
      end
      ROW_SUM_PLAIN:
      begin
        if (!cmd_i[3]) kind_o = K_SUM_PLAIN;
        else if (cmd_i == CMD_SUM_ALL_UNMASKED) kind_o = K_SUM_ALL;
      end
      4'hF:
      begin
        if (cmd_i == CMD_SELF_CAL_BOTH) kind_o = K_CAL_BOTH;
        else if (cmd_i == CMD_SELF_CAL_OFFSET) kind_o = K_CAL_OFFSET;
        else if (cmd_i == CMD_SELF_CAL_GAIN) kind_o = K_CAL_GAIN;
        else if (cmd_i == CMD_SYS_OFFSET_CAL) kind_o = K_SYS_OFFSET;
        else if (cmd_i == CMD_SYS_GAIN_CAL) kind_o = K_SYS_GAIN;
        else if (cmd_i == CMD_SYNC_READY) kind_o = K_SYNC;
        else if (cmd_i == CMD_SLEEP) kind_o = K_SLEEP;
        else if (cmd_i == CMD_RESET) kind_o = K_RESET;
      end
      default: kind_o = K_RESERVED; // Rows 3, 7..B
    endcase
  end

endmodule : sercmd_decode

//--- hw/sercmd_dev.sv
// Module: device end - serial slave with command decoder and actions
`timescale 1ns/1ps
module sercmd_dev
  import sercmd_pkg::*;
#(
  parameter int BANKS = BANK_CNT,
  parameter int BANK_LEN = BANK_BYTES
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  sercmd_if.dev link,
  input wire logic clock_polarity_pin_i,       // 1: clock idles high
  input wire logic [7:0] cal_offset_i,         // Calibration engine offset result
  input wire logic [23:0] cal_gain_i,          // Calibration engine full-scale result
  output logic [7:0] offset_correction_reg_o,
  output logic [23:0] full_scale_reg_o,
  output logic [7:0] config_reg_o,             // Representative config register
  output logic [7:0] checksum_o,
  output logic checksum_valid_o,               // Pulse when checksum is ready
  output logic conv_sync_o,                    // Pulse: realign conversion timing
  output logic sleep_o,
  output logic cont_read_o,
  output logic [7:0] last_cmd_o,
  output logic cmd_valid_o,                    // Pulse per completed byte
  output logic reserved_cmd_o                  // Pulse on reserved code
);
  import sercmd_pkg::*;
  initial
  begin
    if (BANKS < 1 || BANKS > 8 || BANK_LEN < 1 || BANK_LEN > 128)
      $error("sercmd_dev: unsupported RAM geometry");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] sclk_sync_ff, nxt_sclk_sync;     // Stage 0 feeds only stage 1
  logic [1:0] sel_sync_ff, nxt_sel_sync, din_sync_ff, nxt_din_sync;
  logic [1:0] pol_sync_ff, nxt_pol_sync;
  logic sclk_prev_ff, nxt_sclk_prev;           // For edge detection on stage 1
  always_comb
  begin
    nxt_sclk_sync = {sclk_sync_ff[0], link.sclk};
    nxt_sel_sync = {sel_sync_ff[0], link.sel_n};
    nxt_din_sync = {din_sync_ff[0], link.din};
    nxt_pol_sync = {pol_sync_ff[0], clock_polarity_pin_i};
    nxt_sclk_prev = sclk_sync_ff[1];
  end
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sclk_sync_ff <= 2'h0;
      sel_sync_ff <= 2'h3;
      din_sync_ff <= 2'h0;
      pol_sync_ff <= 2'h0;
      sclk_prev_ff <= 1'b0;
    end
    else
    begin
      sclk_sync_ff <= nxt_sclk_sync;
      sel_sync_ff <= nxt_sel_sync;
      din_sync_ff <= nxt_din_sync;
      pol_sync_ff <= nxt_pol_sync;
      sclk_prev_ff <= nxt_sclk_prev;
    end
  end
  // Clock normalised to idle-low so one edge pair serves both polarities
  logic sclk_n_cur, sclk_n_prev, lead_edge, trail_edge, selected;
  assign sclk_n_cur = sclk_sync_ff[1] ^ pol_sync_ff[1];
  assign sclk_n_prev = sclk_prev_ff ^ pol_sync_ff[1];
  assign lead_edge = sclk_n_cur & ~sclk_n_prev;   // Sample edge
  assign trail_edge = ~sclk_n_cur & sclk_n_prev;  // Drive edge
  assign selected = ~sel_sync_ff[1];              // Select high ignores all

  // ----------------------------------------
  // RAM banks (contents untouched by reset command)
  // ----------------------------------------
  logic [7:0] ram_mem [BANKS*BANK_LEN];  // Power-up fill only; no write path here
  // Sum of all bytes, carries dropped, nothing masked
  function automatic logic [7:0] sum_all_banks();
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < BANKS * BANK_LEN; i++)
      acc = acc + ram_mem[i];
    return acc;
  endfunction : sum_all_banks

  // ----------------------------------------
  // Shift engine and command state
  // ----------------------------------------
  logic [7:0] rx_ff, nxt_rx;          // Incoming byte
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] tx_ff, nxt_tx;          // Outgoing byte
  logic dout_ff, nxt_dout;
  logic [7:0] ocr_ff, nxt_ocr;
  logic [23:0] fsr_ff, nxt_fsr;
  logic [7:0] cfg_ff, nxt_cfg, sum_ff, nxt_sum;
  logic sum_vld_ff, nxt_sum_vld, sync_ff, nxt_sync;      // One-cycle pulses
  logic sleep_ff, nxt_sleep, cont_ff, nxt_cont;          // Mode levels
  logic [7:0] last_ff, nxt_last;
  logic cmd_vld_ff, nxt_cmd_vld, resv_ff, nxt_resv;      // One-cycle pulses
  logic [7:0] byte_in;
  sercmd_kind_t kind;
  assign byte_in = {rx_ff[6:0], din_sync_ff[1]};  // MSB arrives first
  sercmd_decode sercmd_decode_i (
    .cmd_i(byte_in),
    .kind_o(kind)
  );
  // Next-state for shifting and command effects
  always_comb
  begin
    nxt_rx = rx_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_tx = tx_ff;
    nxt_dout = dout_ff;
    nxt_ocr = ocr_ff;
    nxt_fsr = fsr_ff;
    nxt_cfg = cfg_ff;
    nxt_sum = sum_ff;
    nxt_sum_vld = 1'b0;
    nxt_sync = 1'b0;
    nxt_sleep = sleep_ff;
    nxt_cont = cont_ff;
    nxt_last = last_ff;
    nxt_cmd_vld = 1'b0;
    nxt_resv = 1'b0;
    if (!selected)
    begin
      // Deselected: frame aborted, partial byte dropped
      nxt_bit_cnt = 3'h0;
      nxt_dout = sum_ff[7];                   // MSB stands before first edge
      nxt_tx = {sum_ff[6:0], sum_ff[7]};
    end
    else if (sleep_ff && lead_edge)
    begin
      // Leading edge wakes; the sleep byte's own last fall must not
      nxt_sleep = 1'b0;
    end
    else if (lead_edge)
    begin
      // Sample input on leading edge, bursts welcome
      nxt_rx = byte_in;
      nxt_bit_cnt = bit_cnt_ff + 3'h1;
      if (bit_cnt_ff == 3'h7)
      begin
        nxt_last = byte_in;
        nxt_cmd_vld = 1'b1;
        unique case (kind)
          K_SUM_ALL:
          begin
            nxt_sum = sum_all_banks();
            nxt_sum_vld = 1'b1;
          end
          K_CAL_BOTH:
          begin
            nxt_ocr = cal_offset_i;
            nxt_fsr = cal_gain_i;
          end
          K_CAL_OFFSET: nxt_ocr = cal_offset_i;
          K_CAL_GAIN: nxt_fsr = cal_gain_i;
          K_SYS_OFFSET: nxt_ocr = cal_offset_i;
          K_SYS_GAIN: nxt_fsr = cal_gain_i;
          K_SYNC: nxt_sync = 1'b1;
          K_SLEEP: nxt_sleep = 1'b1;
          K_RESET:
          begin
            nxt_ocr = OFFSET_REG_RST;
            nxt_fsr = FULL_SCALE_RST;
            nxt_cfg = CFG_REG_RST;
            nxt_cont = 1'b0;                    // RAM left alone
          end
          K_READ_CONT: nxt_cont = 1'b1;
          K_STOP_CONT: nxt_cont = 1'b0;
          K_REG_WRITE: nxt_cfg = byte_in;       // Opcode kept as marker only
          K_RESERVED: nxt_resv = 1'b1;          // Flagged, otherwise ignored
          default: ;                            // Other commands not handled here
        endcase
      end
    end
    else if (trail_edge)
    begin
      // Drive next output bit on the opposite edge, MSB first
      nxt_dout = tx_ff[7];
      nxt_tx = {tx_ff[6:0], tx_ff[7]};
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rx_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      tx_ff <= 8'h00;
      dout_ff <= 1'b0;
      ocr_ff <= OFFSET_REG_RST;
      fsr_ff <= FULL_SCALE_RST;
      cfg_ff <= CFG_REG_RST;
      sum_ff <= 8'h00;
      sum_vld_ff <= 1'b0;
      sync_ff <= 1'b0;
      sleep_ff <= 1'b0;
      cont_ff <= 1'b0;
      last_ff <= 8'h00;
      cmd_vld_ff <= 1'b0;
      resv_ff <= 1'b0;
      for (int i = 0; i < BANKS * BANK_LEN; i++)
        ram_mem[i] <= RAM_FILL_RST + 8'(i);   // Distinct bytes give a non-trivial sum
    end
    else
    begin
      rx_ff <= nxt_rx;
      bit_cnt_ff <= nxt_bit_cnt;
      tx_ff <= nxt_tx;
      dout_ff <= nxt_dout;
      ocr_ff <= nxt_ocr;
      fsr_ff <= nxt_fsr;
      cfg_ff <= nxt_cfg;
      sum_ff <= nxt_sum;
      sum_vld_ff <= nxt_sum_vld;
      sync_ff <= nxt_sync;
      sleep_ff <= nxt_sleep;
      cont_ff <= nxt_cont;
      last_ff <= nxt_last;
      cmd_vld_ff <= nxt_cmd_vld;
      resv_ff <= nxt_resv;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Only data out and its enable are driven; clock and select are inputs here
  assign link.dout = dout_ff;
  assign link.dout_oe = selected;
  assign offset_correction_reg_o = ocr_ff;
  assign full_scale_reg_o = fsr_ff;
  assign config_reg_o = cfg_ff;
  assign checksum_o = sum_ff;
  assign checksum_valid_o = sum_vld_ff;
  assign conv_sync_o = sync_ff;
  assign sleep_o = sleep_ff;
  assign cont_read_o = cont_ff;
  assign last_cmd_o = last_ff;
  assign cmd_valid_o = cmd_vld_ff;
  assign reserved_cmd_o = resv_ff;
endmodule : sercmd_dev

//--- hw/sercmd_host.sv
// Module: controller end - sends one command byte per request
`timescale 1ns/1ps
module sercmd_host
  import sercmd_pkg::*;
#(
  parameter int HALF = CLK_DIV_HALF
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  sercmd_if.host link,
  input wire logic clock_polarity_i,   // Idle level of generated clock
  input wire logic req_valid_i,        // Request to send req_byte_i
  input wire logic [7:0] req_byte_i,
  input wire logic wake_i,             // Request a lone wake pulse
  output logic req_ready_o,
  output logic [7:0] rsp_byte_o,       // Byte shifted back
  output logic rsp_valid_o             // Pulse at frame end
);
  import sercmd_pkg::*;

  initial
  begin
    // Read-back needs five cycles from our fall to settled, synchronised data
    if (HALF < 5 || HALF > 255) $error("sercmd_host: HALF out of range");
  end

  // ----------------------------------------
  // Frame state machine
  // ----------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_LEAD, S_TRAIL, S_DONE} sercmd_hst_t;
  sercmd_hst_t st_ff, nxt_st;
  logic [7:0] div_ff, nxt_div;
  logic [3:0] bits_ff, nxt_bits;   // Bits still to send
  logic [7:0] tx_ff, nxt_tx;
  logic [7:0] rx_ff, nxt_rx;
  logic sel_ff, nxt_sel;           // Select line, active low
  logic sck_ff, nxt_sck;           // Clock, idle-low form
  logic din_ff, nxt_din;
  logic vld_ff, nxt_vld;
  logic [1:0] miso_sync_ff, nxt_miso_sync;

  // Device data is asynchronous to us; two stages first
  always_comb
  begin
    nxt_miso_sync = {miso_sync_ff[0], link.dout};
  end

  // Divider-timed frame: select low, 8 clocks MSB first (1 for wake), select high
  always_comb
  begin
    nxt_st = st_ff;
    nxt_div = (div_ff == 8'h00) ? 8'h00 : div_ff - 8'h01;
    nxt_bits = bits_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_sel = sel_ff;
    nxt_sck = sck_ff;
    nxt_din = din_ff;
    nxt_vld = 1'b0;
    unique case (st_ff)
      S_IDLE:
        if (req_valid_i || wake_i)
        begin
          nxt_sel = 1'b0;
          nxt_tx = {req_byte_i[6:0], 1'b0};
          nxt_din = req_byte_i[7];                 // MSB first
          nxt_bits = wake_i ? 4'h1 : 4'h8;         // Wake is a single pulse
          nxt_div = 8'(HALF);
          nxt_st = S_LEAD;
        end
      S_LEAD:
        if (div_ff == 8'h00)
        begin
          nxt_sck = 1'b1;                          // Sample edge
          nxt_rx = {rx_ff[6:0], miso_sync_ff[1]};  // Device bit settled since last fall
          nxt_div = 8'(HALF);
          nxt_st = S_TRAIL;
        end
      S_TRAIL:
        if (div_ff == 8'h00)
        begin
          nxt_sck = 1'b0;
          nxt_din = tx_ff[7];
          nxt_tx = {tx_ff[6:0], 1'b0};
          nxt_bits = bits_ff - 4'h1;
          nxt_div = 8'(HALF);
          nxt_st = (bits_ff == 4'h1) ? S_DONE : S_LEAD; // Burst, no gaps
        end
      S_DONE:
        if (div_ff == 8'h00)
        begin
          nxt_sel = 1'b1;                          // Held low to the end
          nxt_vld = 1'b1;
          nxt_st = S_IDLE;
        end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_ff <= S_IDLE;
      div_ff <= 8'h00;
      bits_ff <= 4'h0;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
      sel_ff <= 1'b1;
      sck_ff <= 1'b0;
      din_ff <= 1'b0;
      vld_ff <= 1'b0;
      miso_sync_ff <= 2'h0;
    end
    else
    begin
      st_ff <= nxt_st;
      div_ff <= nxt_div;
      bits_ff <= nxt_bits;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      sel_ff <= nxt_sel;
      sck_ff <= nxt_sck;
      din_ff <= nxt_din;
      vld_ff <= nxt_vld;
      miso_sync_ff <= nxt_miso_sync;
    end
  end

  // Polarity applied at the pin only; format unchanged
  assign link.sclk = sck_ff ^ clock_polarity_i;
  assign link.sel_n = sel_ff;
  assign link.din = din_ff;
  assign req_ready_o = (st_ff == S_IDLE);
  assign rsp_byte_o = rx_ff;
  assign rsp_valid_o = vld_ff;

endmodule : sercmd_host

//--- hw/sercmd_if.sv
// Interface: four-wire serial link between controller and converter
`timescale 1ns/1ps
interface sercmd_if;
  logic sel_n;      // Chip select, active low
  logic sclk;       // Serial clock from controller
  logic din;        // Controller to device data
  logic dout;       // Device to controller data
  logic dout_oe;    // Device drives dout while high

  modport dev (input sel_n, input sclk, input din, output dout, output dout_oe);
  modport host (output sel_n, output sclk, output din, input dout, input dout_oe);
endinterface : sercmd_if

//--- hw/sercmd_pkg.sv
// Package: shared constants and types of the serial command decoder
package sercmd_pkg;

  // ----------------------------------------
  // Command byte codes
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_ONCE = 8'h01;    // Single data read
  localparam logic [7:0] CMD_READ_CONT = 8'h03;    // Enter continuous read
  localparam logic [7:0] CMD_STOP_CONT = 8'h0F;    // Leave continuous read
  localparam logic [3:0] ROW_REG_READ = 4'h1;      // Register read row
  localparam logic [3:0] ROW_RAM_READ = 4'h2;      // RAM read row
  localparam logic [3:0] ROW_COPY_REG = 4'h4;      // Copy regs to RAM row
  localparam logic [3:0] ROW_REG_WRITE = 4'h5;     // Register write row
  localparam logic [3:0] ROW_RAM_WRITE = 4'h6;     // RAM write row
  localparam logic [3:0] ROW_COPY_RAM = 4'hC;      // Copy RAM to regs row
  localparam logic [3:0] ROW_SUM_MASKED = 4'hD;    // Masked checksum row
  localparam logic [3:0] ROW_SUM_PLAIN = 4'hE;     // Unmasked checksum row
  localparam logic [7:0] CMD_SUM_REGS = 8'hDF;     // Register checksum
  localparam logic [7:0] CMD_SUM_ALL_UNMASKED = 8'hE8; // Sum of all banks, no mask
  localparam logic [7:0] CMD_SELF_CAL_BOTH = 8'hF0;
  localparam logic [7:0] CMD_SELF_CAL_OFFSET = 8'hF1;
  localparam logic [7:0] CMD_SELF_CAL_GAIN = 8'hF2;
  localparam logic [7:0] CMD_SYS_OFFSET_CAL = 8'hF3;
  localparam logic [7:0] CMD_SYS_GAIN_CAL = 8'hF4;
  localparam logic [7:0] CMD_SYNC_READY = 8'hFC;
  localparam logic [7:0] CMD_SLEEP = 8'hFD;
  localparam logic [7:0] CMD_RESET = 8'hFE;
  localparam logic [3:0] ALL_BANKS_NIBBLE = 4'h8;  // All-bank low nibble

  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int BYTE_W = 8;
  localparam int BANK_CNT = 8;
  localparam int BANK_BYTES = 16;
  localparam logic [7:0] OFFSET_REG_RST = 8'h00;   // Offset correction power-up
  localparam logic [23:0] FULL_SCALE_RST = 24'h40_0000; // Full-scale power-up
  localparam logic [7:0] CFG_REG_RST = 8'h00;      // Config power-up value
  localparam logic [7:0] RAM_FILL_RST = 8'h5B;     // RAM power-up fill base, plus byte index
  localparam int CLK_DIV_HALF = 6;                 // Host link clock half period minus one, cycles

  // ----------------------------------------
  // Decoded command kinds
  // ----------------------------------------
  typedef enum logic [4:0] {
    K_NONE, K_RESERVED, K_READ_ONCE, K_READ_CONT, K_STOP_CONT, K_REG_READ,
    K_RAM_READ, K_COPY_REG, K_REG_WRITE, K_RAM_WRITE, K_COPY_RAM,
    K_SUM_MASKED, K_SUM_REGS, K_SUM_PLAIN, K_SUM_ALL, K_CAL_BOTH,
    K_CAL_OFFSET, K_CAL_GAIN, K_SYS_OFFSET, K_SYS_GAIN, K_SYNC, K_SLEEP,
    K_RESET
  } sercmd_kind_t;

endpackage : sercmd_pkg

//--- verification/sercmd_chk.sv
// Checker: wire-level assertions on the serial command link
`timescale 1ns/1ps
module sercmd_chk
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout_oe,
  input wire logic clock_polarity_i
);
  logic sclk_ff; // Clock level one cycle ago
  logic [3:0] edge_cnt_ff; // Leading edges seen in this frame
  logic [3:0] nxt_edge_cnt;
  // ----------------------------------------
  // Leading-edge counter
  // ----------------------------------------
  always_comb
  begin
    nxt_edge_cnt = edge_cnt_ff;
    if (sel_n)
      nxt_edge_cnt = 4'h0; // Cleared between frames
    else if (sclk != clock_polarity_i && sclk_ff == clock_polarity_i)
      nxt_edge_cnt = edge_cnt_ff + 4'h1;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sclk_ff <= 1'b0;
      edge_cnt_ff <= 4'h0;
    end
    else
    begin
      sclk_ff <= sclk;
      edge_cnt_ff <= nxt_edge_cnt;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_sel_high;
    sel_n [*4];
  endsequence
  sequence s_sel_low;
    !sel_n [*4];
  endsequence
  sequence s_frame_end;
    $rose(sel_n);
  endsequence
  property p_oe_off;
    s_sel_high |-> !dout_oe;
  endproperty
  property p_oe_on;
    s_sel_low |-> dout_oe;
  endproperty
  property p_idle_level;
    sel_n && $past(sel_n) |-> sclk == clock_polarity_i;
  endproperty
  property p_sel_frame;
    $fell(sel_n) |-> !sel_n [*8];
  endproperty
  property p_first_edge;
    $fell(sel_n) |-> $stable(sclk) [*3];
  endproperty
  property p_din_trail;
    !sel_n && $changed(din) |-> sclk == clock_polarity_i;
  endproperty
  property p_half_min;
    $changed(sclk) |=> $stable(sclk) [*2];
  endproperty
  property p_frame_bits;
    s_frame_end |-> edge_cnt_ff == 4'h8 || edge_cnt_ff == 4'h1;
  endproperty
  property p_sclk_in_frame;
    $changed(sclk) |-> !sel_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("dout_oe high while deselected");
  a_oe_on: assert property (p_oe_on) else $error("dout_oe low while selected");
  a_idle_level: assert property (p_idle_level) else $error("sclk idle level wrong");
  a_sel_frame: assert property (p_sel_frame) else $error("select frame too short");
  a_first_edge: assert property (p_first_edge) else $error("sclk moved at select");
  a_din_trail: assert property (p_din_trail) else $error("din moved on lead edge");
  a_half_min: assert property (p_half_min) else $error("sclk half period short");
  a_frame_bits: assert property (p_frame_bits) else $error("frame edge count wrong");
  a_sclk_in_frame: assert property (p_sclk_in_frame) else $error("sclk moved idle");
endmodule : sercmd_chk

//--- verification/serial_command_decoder_tb.sv
// Testbench: both link ends joined, plus a rule-breaking controller
`timescale 1ns/1ps
module serial_command_decoder_tb;
  import sercmd_pkg::*;
  logic clk_i = 1'b0; // System clock
  logic sys_rst_i = 1'b1; // Async reset
  logic clock_polarity_pin = 1'b0; // Clock idle level
  logic rq_v = 1'b0; // Host request
  logic wake = 1'b0; // Host wake request
  logic [7:0] rq_b = 8'h00;
  logic [7:0] cal_o = 8'h00; // Calibration offset result
  logic [23:0] cal_g = 24'h00_0000; // Calibration full-scale result
  logic [7:0] offset_correction_reg, cfg, csum, last, ocr2, last2, rsp_b;
  logic [7:0] din_sh = 8'h00; // Bits seen on din
  logic [23:0] full_scale_reg, fsr2;
  logic csv, syn, slp, cont, rsv, rdy, rsp_v;
  logic seen_syn = 1'b0; // Sticky pulse catchers
  logic seen_csv = 1'b0;
  logic seen_rsv = 1'b0;
  int error_cnt = 0;
  int checks = 0;
  sercmd_if link();
  sercmd_if link2(); // Second link, bench plays controller
  sercmd_dev sercmd_dev_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link.dev),
    .clock_polarity_pin_i(clock_polarity_pin), .cal_offset_i(cal_o), .cal_gain_i(cal_g),
    .offset_correction_reg_o(offset_correction_reg), .full_scale_reg_o(full_scale_reg), .config_reg_o(cfg),
    .checksum_o(csum), .checksum_valid_o(csv), .conv_sync_o(syn), .sleep_o(slp),
    .cont_read_o(cont), .last_cmd_o(last), .cmd_valid_o(), .reserved_cmd_o(rsv));
  sercmd_dev sercmd_dev2_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link2.dev),
    .clock_polarity_pin_i(1'b0), .cal_offset_i(cal_o), .cal_gain_i(cal_g),
    .offset_correction_reg_o(ocr2), .full_scale_reg_o(fsr2), .config_reg_o(),
    .checksum_o(), .checksum_valid_o(), .conv_sync_o(), .sleep_o(),
    .cont_read_o(), .last_cmd_o(last2), .cmd_valid_o(), .reserved_cmd_o());
  sercmd_host sercmd_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link.host),
    .clock_polarity_i(clock_polarity_pin), .req_valid_i(rq_v), .req_byte_i(rq_b), .wake_i(wake),
    .req_ready_o(rdy), .rsp_byte_o(rsp_b), .rsp_valid_o(rsp_v));
  sercmd_chk sercmd_chk_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sel_n(link.sel_n),
    .sclk(link.sclk), .din(link.din), .dout_oe(link.dout_oe), .clock_polarity_i(clock_polarity_pin));
  always #2 clk_i = ~clk_i;
  // Pulses last one cycle, so latch them
  always @(posedge clk_i)
  begin
    if (syn === 1'b1)
      seen_syn <= 1'b1;
    if (csv === 1'b1)
      seen_csv <= 1'b1;
    if (rsv === 1'b1)
      seen_rsv <= 1'b1;
  end
  // Collect din on each leading edge
  always @(link.sclk)
    if (!link.sel_n && link.sclk !== clock_polarity_pin)
      din_sh = {din_sh[6:0], link.din};
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Sum of the power-up RAM fill, carries dropped
  function automatic logic [7:0] exp_sum();
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < BANK_CNT * BANK_BYTES; i++)
      acc = acc + RAM_FILL_RST + 8'(i);
    return acc;
  endfunction : exp_sum
  // One byte through the host, then let effects land
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk_i);
    while (rdy !== 1'b1)
      @(negedge clk_i); // Hold off until the host is idle
    rq_b = b;
    rq_v = 1'b1;
    @(negedge clk_i);
    rq_v = 1'b0;
    while (rsp_v !== 1'b1 && n < 400)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("frame done", 24'h00_0001, 24'(n < 400));
    chk("din order", 24'(b), 24'(din_sh));
    repeat (4) @(negedge clk_i);
  endtask : send
  // Bench controller; 48 ns link clock only inside the frame
  task automatic bang(input logic [7:0] b, input int nb);
    @(negedge clk_i);
    link2.sel_n = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      link2.din = b[7-i];
      #24 link2.sclk = 1'b1;
      #24 link2.sclk = 1'b0;
    end
    #24 chk("oe2 on", 24'h00_0001, 24'(link2.dout_oe));
    link2.sel_n = 1'b1;
    link2.din = ~link2.din; // Released line never shows stale data
    #48 chk("oe2 off", 24'h00_0000, 24'(link2.dout_oe));
  endtask : bang
  task automatic t_reset;
    chk("ocr", 24'(OFFSET_REG_RST), 24'(offset_correction_reg));
    chk("fsr", FULL_SCALE_RST, full_scale_reg);
    chk("cfg", 24'(CFG_REG_RST), 24'(cfg));
    chk("oe idle", 24'h00_0000, 24'(link.dout_oe));
    chk("sclk idle", 24'(clock_polarity_pin), 24'(link.sclk));
  endtask : t_reset
  task automatic t_cal;
    logic [7:0] cmd [5] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4};
    logic [4:0] upo = 5'b01011; // Commands that load offset
    logic [4:0] upg = 5'b10101; // Commands that load full scale
    logic [7:0] eo = 8'h00;
    logic [23:0] eg = FULL_SCALE_RST;
    for (int i = 0; i < 5; i++)
    begin
      cal_o = 8'hA0 + 8'(i);
      cal_g = 24'h12_3400 + 24'(i);
      send(cmd[i]);
      if (upo[i])
        eo = cal_o;
      if (upg[i])
        eg = cal_g;
      chk("cal ocr", 24'(eo), 24'(offset_correction_reg));
      chk("cal fsr", eg, full_scale_reg);
    end
  endtask : t_cal
  task automatic t_pulse;
    logic [7:0] rc [4] = '{8'h30, 8'h7F, 8'h28, 8'hF5}; // Unlisted codes
    send(8'hFC);
    chk("sync", 24'h00_0001, 24'(seen_syn));
    send(8'hE8);
    chk("sum done", 24'h00_0001, 24'(seen_csv));
    chk("sum value", 24'(exp_sum()), 24'(csum));
    chk("no reserved", 24'h00_0000, 24'(seen_rsv));
    for (int i = 0; i < 4; i++)
    begin
      seen_rsv = 1'b0;
      send(rc[i]);
      chk("reserved", 24'h00_0001, 24'(seen_rsv));
      chk("last cmd", 24'(rc[i]), 24'(last));
      chk("sum out", 24'(exp_sum()), 24'(rsp_b));
    end
    chk("ocr kept", 24'h00_00A3, 24'(offset_correction_reg));
  endtask : t_pulse
  task automatic t_cont;
    send(8'h03);
    chk("cont on", 24'h00_0001, 24'(cont));
    send(8'h0F);
    chk("cont stop", 24'h00_0000, 24'(cont));
    send(8'h5A); // Write row, low nibble above 7
    chk("cfg write", 24'h00_005A, 24'(cfg));
    send(8'h03);
    send(8'hFE);
    chk("cont reset", 24'h00_0000, 24'(cont));
    chk("ocr reset", 24'(OFFSET_REG_RST), 24'(offset_correction_reg));
    chk("fsr reset", FULL_SCALE_RST, full_scale_reg);
    chk("cfg reset", 24'(CFG_REG_RST), 24'(cfg));
    send(8'hE8);
    chk("ram kept", 24'(exp_sum()), 24'(csum));
  endtask : t_cont
  task automatic t_sleep;
    int n;
    n = 0;
    send(8'hFD);
    chk("sleep", 24'h00_0001, 24'(slp));
    @(negedge clk_i);
    wake = 1'b1;
    @(negedge clk_i);
    wake = 1'b0;
    while (slp !== 1'b0 && n < 200)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("wake", 24'h00_0000, 24'(slp));
    cal_o = 8'h5C;
    send(8'hF1);
    chk("after wake", 24'h00_005C, 24'(offset_correction_reg));
  endtask : t_sleep
  task automatic t_partial;
    cal_g = 24'h65_4321;
    bang(8'hF1, 4);
    bang(8'hF4, 8);
    repeat (4) @(negedge clk_i);
    chk("part fsr", 24'h65_4321, fsr2);
    chk("part last", 24'h00_00F4, 24'(last2));
    chk("part ocr", 24'(OFFSET_REG_RST), 24'(ocr2));
  endtask : t_partial
  task automatic t_pol;
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    clock_polarity_pin = 1'b1;
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    t_reset();
    cal_o = 8'h3E;
    send(8'hF3);
    chk("pol ocr", 24'h00_003E, 24'(offset_correction_reg));
  endtask : t_pol
  task automatic give_verdict;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    link2.sel_n = 1'b1;
    link2.sclk = 1'b0;
    link2.din = 1'b0;
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    t_reset();
    t_cal();
    t_pulse();
    t_cont();
    t_sleep();
    t_partial();
    t_pol();
    give_verdict();
  end
  // Watchdog, far beyond the expected run
  initial
  begin
    #100000;
    error_cnt++;
    $display("Error watchdog expected done seen hang");
    give_verdict();
  end
endmodule : serial_command_decoder_tb
